// ===== design/cmtmr_pkg.sv
// Constants, types and helpers shared by the compact timer core.
package cmtmr_pkg;

	localparam int CNT_W = 10;
	localparam int CMP_P_W = 3;

	// Selectors of the byte access port.
	localparam logic [1:0] SEL_COUNT_LOW = 2'h0;
	localparam logic [1:0] SEL_COUNT_HIGH = 2'h1;
	localparam logic [1:0] SEL_CMPA_LOW = 2'h2;
	localparam logic [1:0] SEL_CMPA_HIGH = 2'h3;

	// Codes of the clock select field.
	localparam logic [2:0] CKS_SYS4 = 3'h0;
	localparam logic [2:0] CKS_SYS = 3'h1;
	localparam logic [2:0] CKS_H16 = 3'h2;
	localparam logic [2:0] CKS_H64 = 3'h3;
	localparam logic [2:0] CKS_SUB0 = 3'h4;
	localparam logic [2:0] CKS_SUB1 = 3'h5;
	localparam logic [2:0] CKS_EXT_RISE = 3'h6;
	localparam logic [2:0] CKS_EXT_FALL = 3'h7;

	// Prescaler terminal values.
	localparam logic [1:0] SYS_DIV_LAST = 2'h3;
	localparam logic [5:0] H_DIV16_MASK = 6'h0F;
	localparam logic [5:0] H_DIV64_MASK = 6'h3F;

	// Pin function codes, compare match mode and PWM mode.
	localparam logic [1:0] PIN_NONE = 2'h0;
	localparam logic [1:0] PIN_LOW = 2'h1;
	localparam logic [1:0] PIN_HIGH = 2'h2;
	localparam logic [1:0] PIN_TOGGLE = 2'h3;
	localparam logic [1:0] PWM_INACTIVE = 2'h0;
	localparam logic [1:0] PWM_ACTIVE = 2'h1;
	localparam logic [1:0] PWM_RUN = 2'h2;

	// Capture edge select codes.
	localparam logic [1:0] CAP_RISE = 2'h0;
	localparam logic [1:0] CAP_FALL = 2'h1;
	localparam logic [1:0] CAP_BOTH = 2'h2;

	// Values after reset.
	localparam logic [9:0] COUNT_RST = 10'h000;
	localparam logic [9:0] CMPA_RST = 10'h000;
	localparam logic [7:0] BUF_RST = 8'h00;
	localparam logic [1:0] SYS_DIV_RST = 2'h0;
	localparam logic [5:0] H_DIV_RST = 6'h00;

	typedef enum logic [1:0] {
		MODE_CMP = 2'h0,
		MODE_UNDEF = 2'h1,
		MODE_PWM = 2'h2,
		MODE_TIMER = 2'h3
	} cmtmr_mode_t;

	typedef struct packed {
		logic pause;
		logic [2:0] clock_select_field;
		logic timer_on_bit;
		logic [2:0] comparator_p_value;
		cmtmr_mode_t mode;
		logic [1:0] pin_func;
		logic out_init;
		logic polarity;
		logic duty_period_sel;
		logic clear_on_a;
	} cmtmr_ctrl_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [1:0] sel;
		logic [7:0] wdata;
	} cmtmr_acc_t;

	// Span of comparator P in counter clocks; zero stands for a full wrap.
	function automatic logic [10:0] p_span(input logic [2:0] p);
		p_span = (p == 3'h0) ? 11'h400 : {1'b0, p, 7'h00};
	endfunction

endpackage

// ===== design/cmtmr_pin_sync.sv
// Two-stage synchroniser with rising and falling edge pulses for one pin.
`timescale 1ns/1ps
module cmtmr_pin_sync (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic clk_en,
	input wire logic pin,
	output logic rise,
	output logic fall
);
	import cmtmr_pkg::*;

	logic [2:0] sh_reg;
	logic [2:0] sh_next;

	always_comb
	begin
		sh_next = sh_reg;
		if (clk_en)
			sh_next = {sh_reg[1:0], pin}; // see [RULE21]
	end

	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
			sh_reg <= 3'h0;
		else
			sh_reg <= sh_next;
	end

	// Edges are taken only from the settled stages, never from the first one.
	assign rise = clk_en & sh_reg[1] & ~sh_reg[2];
	assign fall = clk_en & ~sh_reg[1] & sh_reg[2];

	chk_sync_rise_delay: assert property (@(posedge ref_clk) disable iff (reset) // see [RULE21]
		rise && $past(clk_en) && $past(clk_en, 2) && $past(clk_en, 3)
		|-> $past(pin, 2) && !$past(pin, 3))
		else $error("Rising edge pulse does not follow the pin by two cycles.");

endmodule

// ===== design/cmtmr_byte_port.sv
// Byte access port with the shared low-byte buffer for counter and comparator A.
`timescale 1ns/1ps
module cmtmr_byte_port (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic clk_en,
	input cmtmr_pkg::cmtmr_acc_t acc,
	input wire logic [9:0] count_value,
	output logic [9:0] cmp_a_value,
	output logic [7:0] rdata
);
	import cmtmr_pkg::*;

	logic [7:0] buf_reg;
	logic [7:0] buf_next;
	logic [9:0] cmpa_reg;
	logic [9:0] cmpa_next;
	logic [7:0] rdata_reg;
	logic [7:0] rdata_next;

	always_comb
	begin
		buf_next = buf_reg;
		cmpa_next = cmpa_reg;
		rdata_next = rdata_reg;
		if (clk_en && acc.wr)
		begin
			unique case (acc.sel)
				SEL_CMPA_LOW: buf_next = acc.wdata; // see [RULE10]
				SEL_CMPA_HIGH: cmpa_next = {acc.wdata[1:0], buf_reg}; // see [RULE11]
				SEL_COUNT_LOW, SEL_COUNT_HIGH: ;
			endcase
		end
		else if (clk_en && acc.rd)
		begin
			unique case (acc.sel)
				SEL_COUNT_HIGH:
				begin
					rdata_next = {6'h00, count_value[9:8]}; // see [RULE12]
					buf_next = count_value[7:0];
				end
				SEL_CMPA_HIGH:
				begin
					rdata_next = {6'h00, cmpa_reg[9:8]}; // see [RULE12]
					buf_next = cmpa_reg[7:0];
				end
				SEL_COUNT_LOW, SEL_CMPA_LOW: rdata_next = buf_reg; // see [RULE13]
			endcase
		end
	end

	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			buf_reg <= BUF_RST;
			cmpa_reg <= CMPA_RST;
			rdata_reg <= 8'h00;
		end
		else
		begin
			buf_reg <= buf_next;
			cmpa_reg <= cmpa_next;
			rdata_reg <= rdata_next;
		end
	end

	assign cmp_a_value = cmpa_reg;
	assign rdata = rdata_reg;

	chk_low_write_buffered: assert property (@(posedge ref_clk) disable iff (reset) // see [RULE10]
		clk_en && acc.wr && acc.sel == SEL_CMPA_LOW
		|=> cmpa_reg == $past(cmpa_reg) && buf_reg == $past(acc.wdata))
		else $error("Low byte write reached the comparator value.");

	chk_high_write_joins: assert property (@(posedge ref_clk) disable iff (reset) // see [RULE11]
		clk_en && acc.wr && acc.sel == SEL_CMPA_HIGH
		|=> cmpa_reg == {$past(acc.wdata[1:0]), $past(buf_reg)})
		else $error("High byte write did not join the buffered low byte.");

	chk_high_read_latch: assert property (@(posedge ref_clk) disable iff (reset) // see [RULE12]
		clk_en && !acc.wr && acc.rd && acc.sel == SEL_COUNT_HIGH
		|=> rdata_reg == {6'h00, $past(count_value[9:8])} && buf_reg == $past(count_value[7:0]))
		else $error("Counter high byte read did not latch the low byte.");

	chk_low_read_buffer: assert property (@(posedge ref_clk) disable iff (reset) // see [RULE13]
		clk_en && !acc.wr && acc.rd && (acc.sel == SEL_COUNT_LOW || acc.sel == SEL_CMPA_LOW)
		|=> rdata_reg == $past(buf_reg))
		else $error("Low byte read did not return the buffer.");

endmodule

// ===== design/cmtmr_core.sv
// Compact timer core: counter, comparators A and P, clock select and output pin.
// Function
// [RULE1] Separate interrupt pulses for comparator A match and comparator P match.
// [RULE2] A match may clear the counter and change the output pin.
// [RULE3] Three-bit field selects system, high, subsidiary or external pin clock.
// [RULE4] External pin clock counts on its rising or falling edge.
// [RULE5] Capture input reacts to rising, falling or both edges.
// [RULE6] In single pulse mode the external clock pin acts as a trigger.
// [RULE7] Compare match mode drives the pin high, low or toggles it.
// [RULE8] PWM mode puts its waveform on the same output pin.
// [RULE9] High bytes are direct; low bytes pass through an 8-bit buffer.
// [RULE10] Comparator A low byte write only fills the buffer.
// [RULE11] Comparator A high byte write also copies the buffer into low byte.
// [RULE12] High byte read returns it and latches the live low byte.
// [RULE13] Low byte read returns the buffer, not the live value.
// [RULE14] Software writes low then high, and reads high then low.
// [RULE15] Three modes: compare match output, timer/event counter, PWM output.
// [RULE16] PWM is edge aligned with either duty or period adjustable.
// [RULE17] Software sets pin sharing and input direction before use.
// [RULE18] A match is the counter equal to the comparator value.
// [RULE19] 10-bit up-counter; P checks top three bits, A all ten.
// [RULE20] Counter clears on enable rise, overflow or selected comparator match.
// [RULE21] Pin inputs are synchronised before edge detection.
`timescale 1ns/1ps
module cmtmr_core (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic clk_en,
	input wire logic fh_tick,
	input wire logic fsub_tick,
	input cmtmr_pkg::cmtmr_ctrl_t ctrl,
	input cmtmr_pkg::cmtmr_acc_t acc,
	output logic [7:0] reg_rdata,
	input wire logic ext_clock_pin,
	input wire logic capture_input_pin,
	input wire logic [1:0] capture_edge_select,
	input wire logic single_pulse_mode,
	output logic timer_output_pin,
	output logic irq_cmp_a,
	output logic irq_cmp_p,
	output logic capture_event,
	output logic [9:0] capture_value,
	output logic ext_trigger
);
	import cmtmr_pkg::*;

	logic ext_rise;
	logic ext_fall;
	logic cap_rise;
	logic cap_fall;
	logic [9:0] cmp_a_value;
	logic [1:0] sys_div_reg;
	logic [1:0] sys_div_next;
	logic [5:0] h_div_reg;
	logic [5:0] h_div_next;
	logic on_prev_reg;
	logic on_prev_next;
	logic [9:0] count_reg;
	logic [9:0] count_next;
	logic level_reg;
	logic level_next;
	logic pin_reg;
	logic pin_next;
	logic irq_a_reg;
	logic irq_a_next;
	logic irq_p_reg;
	logic irq_p_next;
	logic cap_ev_reg;
	logic cap_ev_next;
	logic [9:0] cap_val_reg;
	logic [9:0] cap_val_next;
	logic trig_reg;
	logic trig_next;
	logic on_rise;
	logic run;
	logic src;
	logic tick;
	logic ext_edge;
	logic cap_edge;
	logic [9:0] count_inc;
	logic p_match;
	logic a_match;
	logic clear_on_a;
	logic clear_now;
	logic [10:0] duty_span;
	logic pwm_active;

	cmtmr_pin_sync ext_sync (
		.ref_clk(ref_clk),
		.reset(reset),
		.clk_en(clk_en),
		.pin(ext_clock_pin),
		.rise(ext_rise),
		.fall(ext_fall)
	);

	cmtmr_pin_sync cap_sync (
		.ref_clk(ref_clk),
		.reset(reset),
		.clk_en(clk_en),
		.pin(capture_input_pin),
		.rise(cap_rise),
		.fall(cap_fall)
	);

	// Counter and comparator A are reached byte-wise through one buffer.
	cmtmr_byte_port byte_port (
		.ref_clk(ref_clk),
		.reset(reset),
		.clk_en(clk_en),
		.acc(acc),
		.count_value(count_reg),
		.cmp_a_value(cmp_a_value),
		.rdata(reg_rdata)
	); // see [RULE9]

	assign on_rise = clk_en & ctrl.timer_on_bit & ~on_prev_reg;
	assign run = clk_en & ctrl.timer_on_bit & ~ctrl.pause;
	assign ext_edge = (ctrl.clock_select_field == CKS_EXT_FALL) ? ext_fall : ext_rise; // see [RULE4]

	always_comb
	begin
		unique case (ctrl.clock_select_field) // see [RULE3]
			CKS_SYS4: src = (sys_div_reg == SYS_DIV_LAST);
			CKS_SYS: src = 1'b1;
			CKS_H16: src = fh_tick & ((h_div_reg & H_DIV16_MASK) == H_DIV16_MASK);
			CKS_H64: src = fh_tick & ((h_div_reg & H_DIV64_MASK) == H_DIV64_MASK);
			CKS_SUB0, CKS_SUB1: src = fsub_tick;
			CKS_EXT_RISE: src = ext_rise & ~single_pulse_mode; // see [RULE4] [RULE6]
			CKS_EXT_FALL: src = ext_fall & ~single_pulse_mode; // see [RULE4] [RULE6]
		endcase
	end

	assign tick = run & src & ~on_rise;
	assign count_inc = count_reg + 10'h001;

	// A match is flagged on the tick that brings the counter to the compare value.
	assign p_match = tick & (count_inc[9:7] == ctrl.comparator_p_value)
		& (count_inc[6:0] == 7'h00); // see [RULE18] [RULE19]
	assign a_match = tick & (count_inc == cmp_a_value); // see [RULE18] [RULE19]

	// In PWM mode the period comparator always clears the counter.
	assign clear_on_a = (ctrl.mode == MODE_PWM) ? ctrl.duty_period_sel : ctrl.clear_on_a; // see [RULE16]
	assign clear_now = clear_on_a ? a_match : p_match; // see [RULE2]

	assign duty_span = ctrl.duty_period_sel ? p_span(ctrl.comparator_p_value)
		: {1'b0, cmp_a_value}; // see [RULE16]
	assign pwm_active = ({1'b0, count_reg} < duty_span);

	always_comb
	begin
		sys_div_next = sys_div_reg;
		h_div_next = h_div_reg;
		on_prev_next = on_prev_reg;
		count_next = count_reg;
		if (clk_en)
		begin
			on_prev_next = ctrl.timer_on_bit;
			if (fh_tick)
				h_div_next = h_div_reg + 6'h01;
			if (on_rise)
			begin
				count_next = COUNT_RST; // see [RULE20]
				sys_div_next = SYS_DIV_RST;
			end
			else if (run)
			begin
				sys_div_next = sys_div_reg + 2'h1;
				// Overflow clears through the natural wrap of the increment.
				if (tick)
					count_next = clear_now ? COUNT_RST : count_inc; // see [RULE20] [RULE2]
			end
		end
	end

	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			sys_div_reg <= SYS_DIV_RST;
			h_div_reg <= H_DIV_RST;
			on_prev_reg <= 1'b0;
			count_reg <= COUNT_RST;
		end
		else
		begin
			sys_div_reg <= sys_div_next;
			h_div_reg <= h_div_next;
			on_prev_reg <= on_prev_next;
			count_reg <= count_next;
		end
	end

	always_comb
	begin
		level_next = level_reg;
		if (clk_en)
		begin
			unique case (ctrl.mode) // see [RULE15]
				MODE_CMP:
				begin
					if (on_rise)
						level_next = ctrl.out_init;
					else if (a_match)
					begin
						unique case (ctrl.pin_func) // see [RULE7] [RULE2]
							PIN_NONE: level_next = level_reg;
							PIN_LOW: level_next = 1'b0;
							PIN_HIGH: level_next = 1'b1;
							PIN_TOGGLE: level_next = ~level_reg;
						endcase
					end
				end
				MODE_PWM:
				begin
					if (on_rise)
						level_next = ctrl.out_init;
					else if (ctrl.timer_on_bit)
					begin
						unique case (ctrl.pin_func) // see [RULE8]
							PWM_INACTIVE: level_next = ~ctrl.out_init;
							PWM_ACTIVE: level_next = ctrl.out_init;
							PWM_RUN: level_next = pwm_active ? ctrl.out_init : ~ctrl.out_init;
							default: level_next = level_reg;
						endcase
					end
				end
				default: level_next = level_reg;
			endcase
		end
		pin_next = clk_en ? (level_next ^ ctrl.polarity) : pin_reg;
	end

	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			level_reg <= 1'b0;
			pin_reg <= 1'b0;
		end
		else
		begin
			level_reg <= level_next;
			pin_reg <= pin_next;
		end
	end

	always_comb
	begin
		unique case (capture_edge_select) // see [RULE5]
			CAP_RISE: cap_edge = cap_rise;
			CAP_FALL: cap_edge = cap_fall;
			CAP_BOTH: cap_edge = cap_rise | cap_fall;
			default: cap_edge = 1'b0;
		endcase
		irq_a_next = clk_en ? a_match : irq_a_reg; // see [RULE1]
		irq_p_next = clk_en ? p_match : irq_p_reg; // see [RULE1]
		cap_ev_next = clk_en ? cap_edge : cap_ev_reg;
		cap_val_next = (clk_en && cap_edge) ? count_reg : cap_val_reg;
		trig_next = clk_en ? (single_pulse_mode & ext_edge) : trig_reg; // see [RULE6]
	end

	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			irq_a_reg <= 1'b0;
			irq_p_reg <= 1'b0;
			cap_ev_reg <= 1'b0;
			cap_val_reg <= COUNT_RST;
			trig_reg <= 1'b0;
		end
		else
		begin
			irq_a_reg <= irq_a_next;
			irq_p_reg <= irq_p_next;
			cap_ev_reg <= cap_ev_next;
			cap_val_reg <= cap_val_next;
			trig_reg <= trig_next;
		end
	end

	assign timer_output_pin = pin_reg;
	assign irq_cmp_a = irq_a_reg;
	assign irq_cmp_p = irq_p_reg;
	assign capture_event = cap_ev_reg;
	assign capture_value = cap_val_reg;
	assign ext_trigger = trig_reg;

	chk_irq_a_match: assert property (@(posedge ref_clk) disable iff (reset) // see [RULE1]
		run && !on_rise && src && count_reg + 10'h001 == cmp_a_value |=> irq_cmp_a)
		else $error("Comparator A match gave no interrupt.");

	chk_irq_p_top: assert property (@(posedge ref_clk) disable iff (reset) // see [RULE19]
		clk_en ##1 irq_cmp_p |-> $past(count_reg[6:0]) == 7'h7F
		&& $past(count_reg[9:7]) + 3'h1 == $past(ctrl.comparator_p_value))
		else $error("Comparator P interrupt without a top-bit match.");

	chk_on_clear: assert property (@(posedge ref_clk) disable iff (reset) // see [RULE20]
		clk_en && ctrl.timer_on_bit && !on_prev_reg |=> count_reg == 10'h000)
		else $error("Counter not cleared when the timer was switched on.");

	chk_pause_hold: assert property (@(posedge ref_clk) disable iff (reset) // see [RULE20]
		clk_en && on_prev_reg && ctrl.pause |=> $stable(count_reg))
		else $error("Counter moved while paused.");

	chk_clear_select: assert property (@(posedge ref_clk) disable iff (reset) // see [RULE2]
		p_match && !clear_on_a |=> count_reg == 10'h000)
		else $error("Comparator P match did not clear the counter.");

	chk_toggle_pin: assert property (@(posedge ref_clk) disable iff (reset) // see [RULE7]
		ctrl.mode == MODE_CMP && ctrl.pin_func == PIN_TOGGLE && a_match
		|=> level_reg != $past(level_reg) ##1 1'b1)
		else $error("Toggle on comparator A match did not flip the pin.");

	chk_pwm_level: assert property (@(posedge ref_clk) disable iff (reset) // see [RULE8]
		clk_en && ctrl.mode == MODE_PWM && ctrl.pin_func == PWM_RUN
		&& on_prev_reg && ctrl.timer_on_bit
		|=> timer_output_pin == (($past(pwm_active) ? $past(ctrl.out_init)
		: !$past(ctrl.out_init)) ^ $past(ctrl.polarity)))
		else $error("PWM pin does not follow duty compare.");

	chk_ext_edge_count: assert property (@(posedge ref_clk) disable iff (reset) // see [RULE4]
		run && !on_rise && !single_pulse_mode && ctrl.clock_select_field == CKS_EXT_FALL
		&& ext_fall |=> count_reg != $past(count_reg) || count_reg == 10'h000)
		else $error("External falling edge was not counted.");

	chk_capture_both: assert property (@(posedge ref_clk) disable iff (reset) // see [RULE5]
		clk_en && capture_edge_select == CAP_BOTH && (cap_rise || cap_fall)
		|=> capture_event && capture_value == $past(count_reg))
		else $error("Capture edge missed in both-edge mode.");

endmodule

// ===== test/tb_cmtmr_core.sv
// Self-checking testbench for the compact timer core.
`timescale 1ns/1ps
module tb_cmtmr_core;
	import cmtmr_pkg::*;
	logic ref_clk = 1'b0;
	logic reset;
	logic clk_en;
	logic fh_tick;
	logic fsub_tick;
	cmtmr_ctrl_t ctrl;
	cmtmr_acc_t acc;
	logic [7:0] reg_rdata;
	logic ext_clock_pin = 1'b0;
	logic capture_input_pin;
	logic [1:0] capture_edge_select;
	logic single_pulse_mode;
	logic timer_output_pin, irq_cmp_a, irq_cmp_p, capture_event, ext_trigger;
	logic [9:0] capture_value;
	int error_cnt = 0;
	int n_checks = 0;
	int seed = 80;
	int a_cnt = 0, p_cnt = 0, cap_cnt = 0, trig_cnt = 0, pin_cd = 0, ext_div = 0;
	int n, hi_cnt;
	logic rd_pend = 1'b0;
	logic ext_run = 1'b0;
	logic ext_man = 1'b0;
	logic [9:0] exp_rd[$];
	logic [9:0] exp_pin[$];
	logic [7:0] lo, hi;
	logic [2:0] cks_l[8] = '{CKS_SYS4, CKS_SYS, CKS_H16, CKS_H64, CKS_SUB0, CKS_SUB1,
		CKS_EXT_RISE, CKS_EXT_FALL};
	int min_l[8] = '{16, 4, 66, 258, 4, 4, 30, 30};
	int max_l[8] = '{28, 9, 81, 321, 9, 9, 60, 60};
	logic [1:0] pf_l[4] = '{PIN_LOW, PIN_HIGH, PIN_TOGGLE, PIN_NONE};
	logic init_l[4] = '{1'b1, 1'b0, 1'b1, 1'b0};
	logic pin_l[4] = '{1'b0, 1'b1, 1'b0, 1'b0};
	int er_l[4] = '{1, 0, 1, 0};
	int ef_l[4] = '{0, 1, 1, 0};

	always #5 ref_clk = ~ref_clk;

	cmtmr_core u_dut (.ref_clk(ref_clk), .reset(reset), .clk_en(clk_en), .fh_tick(fh_tick),
		.fsub_tick(fsub_tick), .ctrl(ctrl), .acc(acc), .reg_rdata(reg_rdata),
		.ext_clock_pin(ext_clock_pin), .capture_input_pin(capture_input_pin),
		.capture_edge_select(capture_edge_select), .single_pulse_mode(single_pulse_mode),
		.timer_output_pin(timer_output_pin), .irq_cmp_a(irq_cmp_a), .irq_cmp_p(irq_cmp_p),
		.capture_event(capture_event), .capture_value(capture_value),
		.ext_trigger(ext_trigger));

	task automatic check(input logic [9:0] got, input logic [9:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic conclude;
		$display("checks=%0d errors=%0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic cyc(input int k);
		repeat (k) @(posedge ref_clk);
	endtask

	// One strobe cycle on the byte port; the strobe drops at the next edge.
	task automatic access(input logic w, input logic [1:0] s, input logic [7:0] d);
		@(posedge ref_clk);
		acc.wr <= w;
		acc.rd <= ~w;
		acc.sel <= s;
		acc.wdata <= d;
		@(posedge ref_clk);
		acc.wr <= 1'b0;
		acc.rd <= 1'b0;
	endtask

	task automatic rd(input logic [1:0] s, input logic [9:0] e);
		exp_rd.push_back(e);
		access(1'b0, s, 8'h00);
	endtask

	task automatic set_a(input logic [9:0] v);
		access(1'b1, SEL_CMPA_LOW, v[7:0]);
		access(1'b1, SEL_CMPA_HIGH, {6'h00, v[9:8]});
	endtask

	// Stops the timer, selects a clock and starts it again with a fresh count.
	task automatic restart(input logic [2:0] cks);
		@(posedge ref_clk);
		ctrl.timer_on_bit <= 1'b0;
		ctrl.clock_select_field <= cks;
		@(posedge ref_clk);
		ctrl.timer_on_bit <= 1'b1;
	endtask

	task automatic wait_a(output int k);
		k = 0;
		do
		begin
			@(posedge ref_clk);
			#1;
			k++;
		end
		while (irq_cmp_a !== 1'b1 && k < 2000);
	endtask

	always @(posedge ref_clk)
	begin
		rd_pend <= acc.rd;
		ext_div <= ext_div + 1;
		ext_clock_pin <= ext_run ? ext_div[2] : ext_man;
	end

	// Watches the outputs and takes the oldest expected value when a result shows.
	always @(posedge ref_clk)
	begin
		#1;
		if (rd_pend)
		begin
			if (exp_rd.size() > 0)
				check({2'h0, reg_rdata}, exp_rd.pop_front());
			else
				check(10'h3FF, 10'h000);
		end
		if (pin_cd == 1)
			check({9'h000, timer_output_pin}, exp_pin.pop_front());
		if (pin_cd > 0)
			pin_cd--;
		else if (irq_cmp_a === 1'b1 && exp_pin.size() > 0)
			pin_cd = 2;
		if (irq_cmp_a === 1'b1) a_cnt++;
		if (irq_cmp_p === 1'b1) p_cnt++;
		if (capture_event === 1'b1) cap_cnt++;
		if (ext_trigger === 1'b1) trig_cnt++;
	end

	initial
	begin
		#200000;
		error_cnt++;
		$display("[ERR] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
		conclude();
	end

	initial
	begin
		reset = 1'b1;
		clk_en = 1'b1;
		fh_tick = 1'b1;
		fsub_tick = 1'b1;
		ctrl = '0;
		acc = '0;
		capture_input_pin = 1'b0;
		capture_edge_select = 2'h3;
		single_pulse_mode = 1'b0;
		repeat (6) @(posedge ref_clk);
		reset <= 1'b0;
		rd(SEL_COUNT_HIGH, 10'h000);
		rd(SEL_COUNT_LOW, 10'h000);
		access(1'b1, SEL_COUNT_HIGH, 8'hFF);
		rd(SEL_COUNT_HIGH, 10'h000);
		lo = 8'($random(seed));
		hi = 8'($random(seed));
		set_a({hi[1:0], lo});
		rd(SEL_CMPA_HIGH, {8'h00, hi[1:0]});
		rd(SEL_CMPA_LOW, {2'h0, lo});
		access(1'b1, SEL_CMPA_LOW, ~lo);
		rd(SEL_CMPA_HIGH, {8'h00, hi[1:0]});
		rd(SEL_CMPA_LOW, {2'h0, lo});
		set_a(10'h005);
		ext_run <= 1'b1;
		for (int i = 0; i < 8; i++)
		begin
			restart(cks_l[i]);
			wait_a(n);
			check({9'h000, n >= min_l[i] && n <= max_l[i]}, 10'h001);
		end
		for (int i = 0; i < 4; i++)
		begin
			ctrl.pin_func <= pf_l[i];
			ctrl.out_init <= init_l[i];
			exp_pin.push_back({9'h000, pin_l[i]});
			restart(CKS_SYS);
			wait_a(n);
			cyc(4);
		end
		set_a(10'h3FF);
		ctrl.comparator_p_value <= 3'h1;
		restart(CKS_SYS);
		a_cnt = 0;
		p_cnt = 0;
		cyc(300);
		check(p_cnt[9:0], 10'h002);
		check(a_cnt[9:0], 10'h000);
		ctrl.pause <= 1'b1;
		restart(CKS_SYS);
		cyc(3);
		rd(SEL_COUNT_HIGH, 10'h000);
		rd(SEL_COUNT_LOW, 10'h000);
		// Forty ticks, then a frozen clock enable and a pause hold the count at 40.
		ctrl.pause <= 1'b0;
		cyc(40);
		clk_en <= 1'b0;
		cyc(5);
		clk_en <= 1'b1;
		ctrl.pause <= 1'b1;
		rd(SEL_COUNT_HIGH, 10'h000);
		rd(SEL_COUNT_LOW, 10'h028);
		for (int i = 0; i < 4; i++)
		begin
			@(posedge ref_clk);
			capture_edge_select <= i[1:0];
			capture_input_pin <= 1'b1;
			cap_cnt = 0;
			cyc(8);
			check(cap_cnt[9:0], er_l[i][9:0]);
			capture_input_pin <= 1'b0;
			cap_cnt = 0;
			cyc(8);
			check(cap_cnt[9:0], ef_l[i][9:0]);
		end
		check(capture_value, 10'h028);
		ext_run <= 1'b0;
		ctrl.pause <= 1'b0;
		single_pulse_mode <= 1'b1;
		restart(CKS_EXT_RISE);
		cyc(8);
		trig_cnt = 0;
		ext_man <= 1'b1;
		cyc(8);
		check(trig_cnt[9:0], 10'h001);
		single_pulse_mode <= 1'b0;
		set_a(10'h020);
		for (int pol = 0; pol < 2; pol++)
		begin
			ctrl.mode <= MODE_PWM;
			ctrl.pin_func <= PWM_RUN;
			ctrl.out_init <= 1'b1;
			ctrl.polarity <= pol[0];
			ctrl.duty_period_sel <= 1'b0;
			restart(CKS_SYS);
			cyc(20);
			hi_cnt = 0;
			repeat (256)
			begin
				@(posedge ref_clk);
				#1;
				if (timer_output_pin === 1'b1) hi_cnt++;
			end
			n = pol ? 256 - hi_cnt : hi_cnt;
			check({9'h000, n >= 60 && n <= 68}, 10'h001);
		end
		// The fixed PWM levels follow out_init, with the inverting polarity still set.
		ctrl.pin_func <= PWM_ACTIVE;
		cyc(3);
		check({9'h000, timer_output_pin}, 10'h000);
		ctrl.pin_func <= PWM_INACTIVE;
		cyc(3);
		check({9'h000, timer_output_pin}, 10'h001);
		conclude();
	end
endmodule
